// File: include/ssc_pkg.sv
// Constants for the shared status and configuration register bank.
// Assumes an SMBus target engine outside that turns bus traffic into
// byte-wide register reads and writes on the device clock.
//
// Notes on behaviour
// [RL1] Offset 8 reads channel flags of quads 0 and 1, low nibble quad 0.
// [RL2] Offset 9 reads channel flags of quads 2 and 3, low nibble quad 2.
// [RL3] Offset A bit 7 picks forwarded clock: one digital, zero analog loop chain.
// [RL4] Host enables loop-through in every channel before choosing the analog source.
// [RL5] Offset A bits 6:5 pick common mode: 800, 1000, 1200 mV, or supply tracking.
// [RL6] Offset B bit 6 is a read-only flag set once a reference clock is seen.
// [RL7] Offset B bit 4 set makes the reference input single-ended, else differential.
// [RL8] Offset 5 bits 3:0 cap channels acquiring lock at once; default eight.
// [RL9] Offset C bit 2 holds the converter control logic in reset until cleared.
`default_nettype none
package ssc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_LOCK_LIMIT = 8'h05;
  localparam logic [7:0] OFS_SPARE_A    = 8'h06;
  localparam logic [7:0] OFS_SPARE_B    = 8'h07;
  localparam logic [7:0] OFS_IRQ_LOW    = 8'h08;
  localparam logic [7:0] OFS_IRQ_HIGH   = 8'h09;
  localparam logic [7:0] OFS_FWD_CTL    = 8'h0A;
  localparam logic [7:0] OFS_REF_IN     = 8'h0B;
  localparam logic [7:0] OFS_CONV_CTL   = 8'h0C;

  // Reset values
  localparam logic [3:0] RST_LOCK_LIMIT = 4'h8;
  localparam logic [7:0] RST_SPARE      = 8'h00;
  localparam logic [7:0] RST_FWD_CTL    = 8'h01;
  localparam logic [7:0] RST_REF_IN     = 8'h00;
  localparam logic [7:0] RST_CONV_CTL   = 8'h00;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // Field positions
  localparam int unsigned BIT_FWD_SRC     = 7;
  localparam int unsigned BIT_CM_HI       = 6;
  localparam int unsigned BIT_CM_LO       = 5;
  localparam int unsigned BIT_SWING_HI    = 4;
  localparam int unsigned BIT_SWING_LO    = 3;
  localparam int unsigned BIT_SHORT_PROT  = 1;
  localparam int unsigned BIT_OUT_OFF     = 0;
  localparam int unsigned BIT_REF_PRESENT = 6;
  localparam int unsigned BIT_SINGLE_END  = 4;
  localparam int unsigned BIT_CONV_RST    = 2;

  // Common-mode select codes and one-hot level outputs
  localparam logic [1:0] CM_800MV  = 2'h0;
  localparam logic [1:0] CM_1000MV = 2'h1;
  localparam logic [1:0] CM_1200MV = 2'h2;
  localparam logic [1:0] CM_TRACK  = 2'h3;
  localparam logic [3:0] CM_OH_800   = 4'h1;
  localparam logic [3:0] CM_OH_1000  = 4'h2;
  localparam logic [3:0] CM_OH_1200  = 4'h4;
  localparam logic [3:0] CM_OH_TRACK = 4'h8;

endpackage
`default_nettype wire

// File: logic/ssc_regs.sv
// Shared status and configuration register bank of the retimer.
// Assumes an SMBus target engine drives the byte-wide register port on clk,
// and that channel interrupt levels come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ssc_regs
  import ssc_pkg::*;
#(
  parameter int unsigned NUM_LANES = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Register port from the SMBus target engine
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_rdata,
  output var  logic              reg_rvalid,
  // Channel events and analog status
  input  wire logic [NUM_LANES-1:0] lane_irq,
  input  wire logic              ref_clock_seen,
  // Lock acquisition throttle
  input  wire logic [4:0]        lock_acq_count,
  output logic                   lock_acq_allow,
  output var  logic [3:0]        concurrent_lock_limit,
  // Forwarded reference clock controls
  output var  logic              fwd_clock_source_select,
  output var  logic [3:0]        fwd_clock_common_mode,
  output var  logic [1:0]        fwd_clock_swing,
  output var  logic              fwd_clock_short_protect,
  output var  logic              fwd_clock_output_off,
  // Reference input and converter controls
  output var  logic              ref_input_single_ended,
  output var  logic              converter_reset_ctl
);

  // Register state
  logic [3:0]           lock_limit_ff;
  logic [7:0]           spare_a_ff;
  logic [7:0]           spare_b_ff;
  logic [NUM_LANES-1:0] irq_ff;
  logic [7:0]           fwd_ctl_ff;
  logic [7:0]           ref_in_ff;
  logic                 ref_present_ff;
  logic [7:0]           conv_ctl_ff;
  logic [7:0]           rdata_ff;
  logic                 rvalid_ff;

  logic [3:0]           nxt_lock_limit;
  logic [7:0]           nxt_spare_a;
  logic [7:0]           nxt_spare_b;
  logic [NUM_LANES-1:0] nxt_irq;
  logic [7:0]           nxt_fwd_ctl;
  logic [7:0]           nxt_ref_in;
  logic                 nxt_ref_present;
  logic [7:0]           nxt_conv_ctl;
  logic [7:0]           nxt_rdata;
  logic                 nxt_rvalid;
  logic                 ref_seen_sync;

  // The detect level comes from the analog clock monitor, not from clk logic
  ssc_sync #(
    .WIDTH (1)
  ) u_ref_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (ref_clock_seen),
    .sync_out (ref_seen_sync)
  );

  function automatic logic [3:0] cm_decode(input logic [1:0] code);
    logic [3:0] oh;
    oh = CM_OH_TRACK;
    case (code)
      CM_800MV:  oh = CM_OH_800;
      CM_1000MV: oh = CM_OH_1000;
      CM_1200MV: oh = CM_OH_1200;
      CM_TRACK:  oh = CM_OH_TRACK;
      default:   oh = CM_OH_TRACK;
    endcase
    return oh;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Write path and status capture
  always_comb
  begin
    nxt_lock_limit  = lock_limit_ff;
    nxt_spare_a     = spare_a_ff;
    nxt_spare_b     = spare_b_ff;
    nxt_fwd_ctl     = fwd_ctl_ff;
    nxt_ref_in      = ref_in_ff;
    nxt_conv_ctl    = conv_ctl_ff;
    nxt_irq         = lane_irq; // RL1 RL2
    // Sticky: once seen, the flag stays until reset; software cannot clear it
    nxt_ref_present = ref_present_ff | ref_seen_sync; // RL6
    if (reg_wr)
    begin
      if (hit(reg_addr, OFS_LOCK_LIMIT))
        nxt_lock_limit = reg_wdata[3:0]; // RL8
      if (hit(reg_addr, OFS_SPARE_A))
        nxt_spare_a = reg_wdata;
      if (hit(reg_addr, OFS_SPARE_B))
        nxt_spare_b = reg_wdata;
      if (hit(reg_addr, OFS_FWD_CTL))
        nxt_fwd_ctl = reg_wdata; // RL3 RL5
      if (hit(reg_addr, OFS_REF_IN))
        nxt_ref_in = reg_wdata; // RL7
      if (hit(reg_addr, OFS_CONV_CTL))
        nxt_conv_ctl = reg_wdata; // RL9
    end
  end

  // Read path; unmapped offsets read as zero
  always_comb
  begin
    nxt_rvalid = reg_rd;
    nxt_rdata  = rdata_ff;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_LOCK_LIMIT: nxt_rdata = {4'h0, lock_limit_ff};
        OFS_SPARE_A:    nxt_rdata = spare_a_ff;
        OFS_SPARE_B:    nxt_rdata = spare_b_ff;
        OFS_IRQ_LOW:    nxt_rdata = irq_ff[7:0]; // RL1
        OFS_IRQ_HIGH:   nxt_rdata = irq_ff[15:8]; // RL2
        OFS_FWD_CTL:    nxt_rdata = fwd_ctl_ff;
        OFS_REF_IN:
        begin
          nxt_rdata = ref_in_ff;
          nxt_rdata[BIT_REF_PRESENT] = ref_present_ff; // RL6
        end
        OFS_CONV_CTL:   nxt_rdata = conv_ctl_ff;
        default:        nxt_rdata = RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lock_limit_ff  <= RST_LOCK_LIMIT;
      spare_a_ff     <= RST_SPARE;
      spare_b_ff     <= RST_SPARE;
      irq_ff         <= '0;
      fwd_ctl_ff     <= RST_FWD_CTL;
      ref_in_ff      <= RST_REF_IN;
      ref_present_ff <= 1'b0;
      conv_ctl_ff    <= RST_CONV_CTL;
      rdata_ff       <= RST_ZERO;
      rvalid_ff      <= 1'b0;
    end
    else
    begin
      lock_limit_ff  <= nxt_lock_limit;
      spare_a_ff     <= nxt_spare_a;
      spare_b_ff     <= nxt_spare_b;
      irq_ff         <= nxt_irq;
      fwd_ctl_ff     <= nxt_fwd_ctl;
      ref_in_ff      <= nxt_ref_in;
      ref_present_ff <= nxt_ref_present;
      conv_ctl_ff    <= nxt_conv_ctl;
      rdata_ff       <= nxt_rdata;
      rvalid_ff      <= nxt_rvalid;
    end
  end

  // Outputs
  assign reg_rdata               = rdata_ff;
  assign reg_rvalid              = rvalid_ff;
  assign concurrent_lock_limit   = lock_limit_ff;
  // A new channel may start acquiring only below the cap
  assign lock_acq_allow          = lock_acq_count < {1'b0, lock_limit_ff}; // RL8
  // Analog source needs loop-through enabled in every channel by the host
  assign fwd_clock_source_select = fwd_ctl_ff[BIT_FWD_SRC]; // RL3
  assign fwd_clock_common_mode   = cm_decode(fwd_ctl_ff[BIT_CM_HI:BIT_CM_LO]); // RL5
  assign fwd_clock_swing         = fwd_ctl_ff[BIT_SWING_HI:BIT_SWING_LO];
  assign fwd_clock_short_protect = fwd_ctl_ff[BIT_SHORT_PROT];
  assign fwd_clock_output_off    = fwd_ctl_ff[BIT_OUT_OFF];
  assign ref_input_single_ended  = ref_in_ff[BIT_SINGLE_END]; // RL7
  assign converter_reset_ctl     = conv_ctl_ff[BIT_CONV_RST]; // RL9

  // Checks
  sequence wr_at(logic [7:0] ofs);
    reg_wr && reg_addr == ofs;
  endsequence

  sequence rd_at(logic [7:0] ofs);
    reg_rd && reg_addr == ofs && !reg_wr;
  endsequence

  irq_low_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RL1
    rd_at(OFS_IRQ_LOW) |=> reg_rvalid && reg_rdata == $past(irq_ff[7:0]))
    else $error("Quad 0/1 flags read wrong");

  irq_high_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RL2
    ##1 rd_at(OFS_IRQ_HIGH) |=> reg_rdata == $past(lane_irq[15:8], 2))
    else $error("Quad 2/3 flags read wrong");

  fwd_src_write_a: assert property (@(posedge clk) disable iff (sys_rst) // RL3
    wr_at(OFS_FWD_CTL) |=> fwd_clock_source_select == $past(reg_wdata[BIT_FWD_SRC]))
    else $error("Forwarded clock source not taken from write");

  cm_onehot_a: assert property (@(posedge clk) disable iff (sys_rst) // RL5
    $onehot(fwd_clock_common_mode) &&
    (fwd_clock_common_mode == CM_OH_800) == (fwd_ctl_ff[BIT_CM_HI:BIT_CM_LO] == CM_800MV))
    else $error("Common-mode decode wrong");

  ref_flag_sticky_a: assert property (@(posedge clk) disable iff (sys_rst) // RL6
    ref_present_ff |=> ref_present_ff)
    else $error("Reference present flag dropped");

  ref_flag_set_a: assert property (@(posedge clk) disable iff (sys_rst) // RL6
    ref_clock_seen [*3] |=> ref_present_ff)
    else $error("Reference present flag not set in three cycles");

  single_end_a: assert property (@(posedge clk) disable iff (sys_rst) // RL7
    wr_at(OFS_REF_IN) ##1 !reg_wr [*2] |->
      ref_input_single_ended == $past(reg_wdata[BIT_SINGLE_END], 2))
    else $error("Single-ended select not held");

  lock_cap_a: assert property (@(posedge clk) disable iff (sys_rst) // RL8
    lock_acq_count >= 5'(concurrent_lock_limit) |-> !lock_acq_allow)
    else $error("Lock start allowed at the cap");

  conv_rst_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RL9
    converter_reset_ctl && !(reg_wr && reg_addr == OFS_CONV_CTL) |=> converter_reset_ctl)
    else $error("Converter reset released without a write");

endmodule
`default_nettype wire

// File: logic/ssc_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the source holds each level for at least two clock periods.
`timescale 1ns/1ps
`default_nettype none
module ssc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb
  begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_ff  <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff  <= nxt_meta;
      sync_out <= nxt_sync;
    end
  end

endmodule
`default_nettype wire

// File: tb/ssc_host_model.sv
// Host model standing in for the SMBus engine that drives the register port.
// Assumes the bank takes requests on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model
  import ssc_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Register port
  output var  logic [ADDR_W-1:0] reg_addr,
  output var  logic              reg_wr,
  output var  logic [DATA_W-1:0] reg_wdata,
  output var  logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_rvalid
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // Released lines show the inverse, so a stale value never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk);
    v = reg_rvalid;
    d = reg_rdata;
  endtask
  // Callers enable loop-through in every channel before choosing the analog chain
  task automatic pick_analog_source(input logic [7:0] ctl);
    wr(OFS_FWD_CTL, ctl & 8'h7F);
  endtask
endmodule
`default_nettype wire

// File: tb/ssc_regs_tb.sv
// Self-checking bench for the shared register bank.
// Assumes the host model drives the register port; the bench drives status.
`timescale 1ns/1ps
`default_nettype none
module ssc_regs_tb;
  import ssc_pkg::*;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [15:0] lane_irq;
  logic        ref_clock_seen;
  logic [4:0]  lock_acq_count;
  logic        lock_acq_allow;
  logic [3:0]  cm;
  logic [3:0]  lim;
  logic [1:0]  swing;
  logic        scp;
  logic        off;
  logic        src;
  logic        single;
  logic        conv;
  int          fails = 0;
  int          compares = 0;
  logic [7:0]  d;
  logic        v;
  ssc_regs ssc_regs_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .lane_irq(lane_irq), .ref_clock_seen(ref_clock_seen),
    .lock_acq_count(lock_acq_count), .lock_acq_allow(lock_acq_allow),
    .concurrent_lock_limit(lim), .fwd_clock_source_select(src),
    .fwd_clock_common_mode(cm), .fwd_clock_swing(swing), .fwd_clock_short_protect(scp),
    .fwd_clock_output_off(off), .ref_input_single_ended(single),
    .converter_reset_ctl(conv));
  ssc_host_model ssc_host_model_inst (.clk(clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    ssc_host_model_inst.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
    // The read strobe is one cycle, so the valid pulse must be gone a cycle later
    @(negedge clk) chk({7'h00, reg_rvalid}, 8'h00);
  endtask
  task automatic allow(input logic [4:0] n, input logic e);
    @(posedge clk) lock_acq_count <= n;
    @(negedge clk) chk({7'h00, lock_acq_allow}, {7'h00, e});
  endtask
  task automatic t_reset();
    rchk(OFS_LOCK_LIMIT, 8'h08);
    rchk(OFS_SPARE_A, 8'h00);
    rchk(OFS_SPARE_B, 8'h00);
    rchk(OFS_IRQ_LOW, 8'h00);
    rchk(OFS_IRQ_HIGH, 8'h00);
    rchk(OFS_FWD_CTL, 8'h01);
    rchk(OFS_REF_IN, 8'h00);
    rchk(OFS_CONV_CTL, 8'h00);
    rchk(8'h20, 8'h00);
    chk({4'h0, cm}, 8'h01);
    chk({6'h00, swing}, 8'h00);
    chk({6'h00, scp, off}, 8'h01);
    chk({4'h0, lim}, 8'h08);
    chk({7'h00, single}, 8'h00);
    allow(5'd7, 1'b1);
    allow(5'd8, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_irq();
    @(posedge clk) lane_irq <= 16'hA53C;
    rchk(OFS_IRQ_LOW, 8'h3C);
    rchk(OFS_IRQ_HIGH, 8'hA5);
    ssc_host_model_inst.wr(OFS_IRQ_LOW, 8'hFF);
    rchk(OFS_IRQ_LOW, 8'h3C);
    @(posedge clk) lane_irq <= 16'h0000;
    rchk(OFS_IRQ_HIGH, 8'h00);
    $display("test irq done");
  endtask
  task automatic t_fwd();
    ssc_host_model_inst.wr(OFS_FWD_CTL, 8'h9A);
    chk({7'h00, src}, 8'h01);
    chk({6'h00, swing}, 8'h03);
    chk({6'h00, scp, off}, 8'h02);
    rchk(OFS_FWD_CTL, 8'h9A);
    for (int i = 0; i < 4; i++)
    begin
      ssc_host_model_inst.pick_analog_source({1'b0, i[1:0], 5'h00});
      chk({4'h0, cm}, 8'h01 << i);
      chk({7'h00, src}, 8'h00);
    end
    $display("test fwd done");
  endtask
  task automatic t_ref();
    ssc_host_model_inst.wr(OFS_REF_IN, 8'hFF);
    chk({7'h00, single}, 8'h01);
    rchk(OFS_REF_IN, 8'hBF);
    ssc_host_model_inst.wr(OFS_REF_IN, 8'h00);
    chk({7'h00, single}, 8'h00);
    @(posedge clk) ref_clock_seen <= 1'b1;
    repeat (4) @(posedge clk);
    ref_clock_seen <= 1'b0;
    rchk(OFS_REF_IN, 8'h40);
    $display("test ref done");
  endtask
  task automatic t_conv();
    ssc_host_model_inst.wr(OFS_CONV_CTL, 8'h04);
    repeat (3) @(negedge clk);
    chk({7'h00, conv}, 8'h01);
    ssc_host_model_inst.wr(OFS_CONV_CTL, 8'h00);
    chk({7'h00, conv}, 8'h00);
    $display("test conv done");
  endtask
  task automatic t_lock();
    ssc_host_model_inst.wr(OFS_LOCK_LIMIT, 8'hFF);
    rchk(OFS_LOCK_LIMIT, 8'h0F);
    chk({4'h0, lim}, 8'h0F);
    allow(5'd14, 1'b1);
    allow(5'd15, 1'b0);
    ssc_host_model_inst.wr(OFS_LOCK_LIMIT, 8'h00);
    allow(5'd0, 1'b0);
    ssc_host_model_inst.wr(OFS_SPARE_A, 8'h5A);
    rchk(OFS_SPARE_A, 8'h5A);
    ssc_host_model_inst.wr(OFS_SPARE_B, 8'hA5);
    rchk(OFS_SPARE_B, 8'hA5);
    ssc_host_model_inst.wr(8'h20, 8'hFF);
    rchk(8'h20, 8'h00);
    $display("test lock done");
  endtask
  // Mid-run reset must clear the sticky detect flag and all written controls
  task automatic t_rerst();
    ssc_host_model_inst.wr(OFS_CONV_CTL, 8'h04);
    @(posedge clk) sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(OFS_REF_IN, 8'h00);
    rchk(OFS_FWD_CTL, 8'h01);
    chk({7'h00, conv}, 8'h00);
    chk({4'h0, lim}, 8'h08);
    $display("test rerst done");
  endtask
  task automatic conclude();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #20000;
    fails++;
    conclude();
  end
  initial
  begin
    sys_rst = 1'b1;
    lane_irq = 16'h0000;
    ref_clock_seen = 1'b0;
    lock_acq_count = 5'd0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_irq();
    t_fwd();
    t_ref();
    t_conv();
    t_lock();
    t_rerst();
    conclude();
  end
endmodule
`default_nettype wire
